// >>> pkg/cidcs_consts.vh
// Register offsets, field positions, reset values and timing counts for
// the caller identification control and status block.
// Assumes a 200 MHz clock and 32-bit AXI4-Lite word addressing.
`ifndef CIDCS_CONSTS_VH
`define CIDCS_CONSTS_VH

// Printed index of the received byte register; byte address is index * 4.
`define CIDCS_IDX_RX_BYTE 8'h0e
`define CIDCS_ADDR_RX_BYTE 8'h38
`define CIDCS_ADDR_CTRL1 8'h28
`define CIDCS_ADDR_STAT2 8'h2c
`define CIDCS_ADDR_CTRL3 8'h30

// Line interrupt and override control fields.
`define CIDCS_B_CAR_OVR 0
`define CIDCS_B_RING_OVR 1
`define CIDCS_B_CAR_IE 4
`define CIDCS_B_CAR_IF 5
`define CIDCS_B_RING_IE 6
`define CIDCS_B_RING_IF 7

// Line detect status and detector power enable fields.
`define CIDCS_B_CAR_N 0
`define CIDCS_B_RING_N 1
`define CIDCS_B_SER 2
`define CIDCS_B_CAR_PWR 5
`define CIDCS_B_RING_PWR 6

// Override enable and receiver control and status fields.
`define CIDCS_B_CAR_OE 0
`define CIDCS_B_RING_OE 1
`define CIDCS_B_RDY 2
`define CIDCS_B_RDY_IE 3
`define CIDCS_B_RX_EN 4
`define CIDCS_B_RAW_SEL 7

// Override bits come out of reset at one, meaning not forced.
`define CIDCS_OVR_RESET 1'b1

// Carrier qualification times in microseconds and the clock rate in MHz.
`define CIDCS_CLK_MHZ 200
`define CIDCS_CAR_VALID_US 25000
`define CIDCS_CAR_DROP_US 8000

`endif

// >>> test/cidcs_front_model.sv
// Behavioural analog front end: carrier energy, ring and demodulator.
// Assumes the bench calls its tasks; lines change just after an edge.
module cidcs_front_model (
    // Pacing clock.
    input logic aclk,
    // Lines toward the block.
    output logic carrier_raw,
    output logic ring_raw_n,
    output logic demod_cooked,
    output logic demod_raw,
    output logic demod_bit_strobe
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle line: no carrier, no ring, demodulator marking high.
    initial begin
        carrier_raw = 1'b0;
        ring_raw_n = 1'b1;
        demod_cooked = 1'b1;
        demod_raw = 1'b1;
        demod_bit_strobe = 1'b0;
    end

    task automatic set_lines(input logic c, input logic r);
        @(posedge aclk);
        carrier_raw <= c;
        ring_raw_n <= r;
    endtask

    task automatic set_demod(input logic v);
        @(posedge aclk);
        demod_cooked <= v;
        demod_raw <= v;
    endtask

    // Lowest bit first; the raw line carries the inverse so that a wrong
    // source select shows in the byte. Each level holds nine clocks, the strobe high for four.
    task automatic send_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            @(posedge aclk);
            demod_cooked <= b[i];
            demod_raw <= !b[i];
            repeat (4) @(posedge aclk);
            demod_bit_strobe <= 1'b1;
            repeat (4) @(posedge aclk);
            demod_bit_strobe <= 1'b0;
        end
    endtask
endmodule

// >>> test/cidcs_monitor.sv
// Checker on the ports of the caller identification register block.
// Assumes the master offers write address and data in the same cycle.
`include "cidcs_consts.vh"
module cidcs_monitor (
    // Clock and reset.
    input logic aclk,
    input logic aresetn,
    // Register bus.
    input logic [7:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [7:0] s_axi_araddr,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0] s_axi_rresp,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    // Power enables and interrupt.
    input logic carrier_power_up,
    input logic ring_power_up,
    input logic irq
);
    logic pw_sel_reg;
    logic [1:0] pw_val_reg;
    wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready;

    // Last write aimed at the power enables.
    always @(posedge aclk) begin
        if (!aresetn) begin
            pw_sel_reg <= 1'b0;
        end else if (wr_take) begin
            pw_sel_reg <= s_axi_awaddr == `CIDCS_ADDR_STAT2 && s_axi_wstrb[0];
            pw_val_reg <= s_axi_wdata[6:5];
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Bus answers stand until taken and arrive on time; a pending read answer blocks new reads.
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read answer late");
    wr_answer_a: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    bad_read_a: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr == 8'h3c |=> s_axi_rresp == 2'b10)
        else $error("unmapped read not refused");
    // Power enables take the written value by the time of the response.
    power_write_a: assert property ($rose(s_axi_bvalid) && pw_sel_reg |->
        {ring_power_up, carrier_power_up} == pw_val_reg)
        else $error("power enable not written");
    upper_zero_a: assert property (s_axi_rvalid |->
        s_axi_rdata[31:8] == '0) else $error("upper read bits set");
    irq_reset_a: assert property ($rose(aresetn) |-> !irq)
        else $error("interrupt high after reset");

    cover property (wr_take && s_axi_awaddr == `CIDCS_ADDR_STAT2);
    cover property ($rose(irq));
    cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule

bind cidcs_top cidcs_monitor u_cidcs_monitor (.*);

// >>> test/cidcs_tb_top.sv
// Self-checking bench for the caller identification register block.
// Assumes the front end model and the bound checker are compiled first.
`include "cidcs_consts.vh"
module cidcs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // Short qualifier counts keep the run brief.
    localparam int VCYC = 20;
    localparam int DCYC = 10;
    localparam logic [7:0] A1 = `CIDCS_ADDR_CTRL1, A2 = `CIDCS_ADDR_STAT2;
    localparam logic [7:0] A3 = `CIDCS_ADDR_CTRL3, AR = `CIDCS_ADDR_RX_BYTE;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, carrier_power_up, ring_power_up, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic carrier_raw, ring_raw_n, demod_cooked, demod_raw, demod_bit_strobe;
    logic [7:0] cfg [4] = '{8'h18, 8'h98, 8'h90, 8'h08};
    logic [7:0] exp_q [$];
    logic [7:0] b;
    int miscompares = 0, total_checks = 0;

    cidcs_top #(.VALID_CYC(VCYC), .DROP_CYC(DCYC)) u_cidcs_top (.*);
    cidcs_front_model u_cidcs_front_model (.*);

    initial begin
        forever #2.5 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Address and data go out together; each is dropped once taken.
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
            input logic [3:0] s, input logic [1:0] er);
        logic at, wt, more;
        s_axi_awaddr <= a;
        s_axi_wdata <= (32'($urandom()) & 32'hffff_ff00) | d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            at = s_axi_awvalid && s_axi_awready;
            wt = s_axi_wvalid && s_axi_wready;
            more = (s_axi_awvalid && !at) || (s_axi_wvalid && !wt);
            @(posedge aclk);
            if (at) s_axi_awvalid <= 1'b0;
            if (wt) s_axi_wvalid <= 1'b0;
        end while (more);
        do @(negedge aclk); while (!s_axi_bvalid);
        chk(s_axi_bresp, er);
        @(posedge aclk);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e,
            input logic [1:0] er);
        logic t;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            t = s_axi_arvalid && s_axi_arready;
            @(posedge aclk);
            if (t) s_axi_arvalid <= 1'b0;
        end while (!t);
        do @(negedge aclk); while (!s_axi_rvalid);
        chk(s_axi_rdata, {24'h00_0000, e});
        chk(s_axi_rresp, er);
        @(posedge aclk);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic irq_is(input logic e);
        @(negedge aclk);
        chk(irq, e);
        @(posedge aclk);
    endtask

    task automatic print_verdict();
        if (miscompares == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Cuts a hang.
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        print_verdict();
    end

    initial begin
        void'($urandom(20938));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // Reset values, refusals and a write with no byte lane.
        rd(A1, 8'h03, 2'b00);
        rd(A2, 8'h07, 2'b00);
        rd(A3, 8'h00, 2'b00);
        rd(8'h3c, 8'h00, 2'b10);
        wr(AR, 8'h55, 4'hf, 2'b10);
        wr(A1, 8'h50, 4'h0, 2'b00);
        rd(A1, 8'h03, 2'b00);
        wr(A1, 8'h50, 4'hf, 2'b00);
        rd(A2, 8'h07, 2'b00);
        irq_is(1'b0);
        // Forced detect per source: flag, shared interrupt, clearing.
        for (int k = 0; k < 2; k++) begin
            wr(A3, 8'(1 << k), 4'hf, 2'b00);
            rd(A2, 8'(7 ^ (1 << k)), 2'b00);
            rd(A1, 8'(8'h50 | (8'h20 << 2 * k)), 2'b00);
            irq_is(1'b1);
            wr(A1, 8'(8'h50 | (8'h20 << 2 * k)), 4'hf, 2'b00);
            rd(A1, 8'(8'h50 | (8'h20 << 2 * k)), 2'b00);
            wr(A1, 8'h50, 4'hf, 2'b00);
            rd(A1, 8'h50, 2'b00);
            irq_is(1'b0);
        end
        wr(A3, 8'h00, 4'hf, 2'b00);
        // Real carrier: too short, then long enough with power on.
        wr(A1, 8'h53, 4'hf, 2'b00);
        u_cidcs_front_model.set_lines(1'b1, 1'b0);
        repeat (VCYC + 10) @(posedge aclk);
        rd(A2, 8'h07, 2'b00);
        u_cidcs_front_model.set_lines(1'b0, 1'b0);
        wr(A2, 8'h20, 4'hf, 2'b00);
        u_cidcs_front_model.set_lines(1'b1, 1'b0);
        repeat (VCYC / 2) @(posedge aclk);
        u_cidcs_front_model.set_lines(1'b0, 1'b0);
        rd(A2, 8'h27, 2'b00);
        u_cidcs_front_model.set_lines(1'b1, 1'b0);
        repeat (VCYC + 10) @(posedge aclk);
        u_cidcs_front_model.set_lines(1'b0, 1'b0);
        repeat (DCYC / 2) @(posedge aclk);
        u_cidcs_front_model.set_lines(1'b1, 1'b0);
        repeat (8) @(posedge aclk);
        rd(A2, 8'h26, 2'b00);
        rd(A1, 8'h73, 2'b00);
        wr(A2, 8'h60, 4'hf, 2'b00);
        repeat (8) @(posedge aclk);
        u_cidcs_front_model.set_demod(1'b0);
        repeat (8) @(posedge aclk);
        rd(A2, 8'h60, 2'b00);
        rd(A1, 8'hf3, 2'b00);
        wr(A1, 8'h03, 4'hf, 2'b00);
        // Byte receiver: source select, interrupt gate, enable.
        foreach (cfg[i]) begin
            wr(A3, cfg[i], 4'hf, 2'b00);
            b = 8'($urandom());
            u_cidcs_front_model.send_byte(b);
            repeat (4) @(posedge aclk);
            if (cfg[i][4]) exp_q.push_back(cfg[i][7] ? ~b : b);
            rd(A3, cfg[i] | {5'h00, cfg[i][4], 2'h0}, 2'b00);
            irq_is(cfg[i][4] && cfg[i][3]);
            // Read promptly so no character is overwritten.
            if (cfg[i][4]) rd(AR, exp_q.pop_front(), 2'b00);
            rd(A3, cfg[i], 2'b00);
        end
        // Carrier dropout after silence; serial bit returns high.
        u_cidcs_front_model.set_lines(1'b0, 1'b1);
        repeat (DCYC + 10) @(posedge aclk);
        rd(A2, 8'h67, 2'b00);
        print_verdict();
    end
endmodule

// >>> verilog/cidcs_qual.v
// Carrier qualifier: synchronises the raw carrier energy pin and declares
// a valid carrier after a continuous presence and drops it after silence.
// Assumes the raw pin is asynchronous to aclk.
`include "cidcs_consts.vh"

module cidcs_qual #(
    parameter VALID_CYC = 5000000,
    parameter DROP_CYC = 1600001
) (
    // Clock and reset.
    input wire aclk,
    input wire aresetn,
    // Detector enable and raw energy input.
    input wire enable,
    input wire raw_in,
    // Qualified carrier, high while valid.
    output reg valid
);
    reg sync1_reg;
    reg sync2_reg;
    reg sync3_reg;
    reg level_reg;
    reg [22:0] cnt_reg;

    // Three-stage synchroniser; a change counts once stages two and three
    // agree, so the first stage feeds nothing but the second.
    always @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
            level_reg <= 1'b0;
        end else begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            if (sync2_reg == sync3_reg)
                level_reg <= sync3_reg;
        end
    end

    // Any agreement with the current verdict restarts the count, so the
    // presence or silence must be continuous.
    always @(posedge aclk) begin
        if (!aresetn || !enable) begin
            cnt_reg <= 23'h00_0000;
            valid <= 1'b0;
        end else if (level_reg == valid) begin
            cnt_reg <= 23'h00_0000;
        end else if (!valid && cnt_reg >= VALID_CYC[22:0] - 23'd1) begin
            cnt_reg <= 23'h00_0000;
            valid <= 1'b1; // RQ20
        end else if (valid && cnt_reg >= DROP_CYC[22:0] - 23'd1) begin
            cnt_reg <= 23'h00_0000;
            valid <= 1'b0; // RQ20
        end else begin
            cnt_reg <= cnt_reg + 23'd1;
        end
    end
endmodule

// >>> verilog/cidcs_top.v
// Caller identification control and status registers behind AXI4-Lite,
// with override logic, interrupt flags and the serial-to-byte receiver.
// Assumes the analog demodulator and ring qualifier drive plain pins.
//
// Function
// (RQ1) Ring override bit forces ring; resets one.
// (RQ2) Carrier interrupt from real or forced carrier.
// (RQ3) Carrier flag set on detect; requests interrupt.
// (RQ4) Carrier flag cleared only by written zero.
// (RQ5) All flags share one interrupt request.
// (RQ6) Ring interrupt from real or forced ring.
// (RQ7) Ring flag set on detect; zero clears.
// (RQ8) Status bit shows active-low carrier detect.
// (RQ9) Status bit shows active-low ring detect.
// (RQ10) Serial bit follows demodulator under carrier, else high.
// (RQ11) Carrier power-up enables carrier detection.
// (RQ12) Ring power-up enables ring detection.
// (RQ13) Carrier override enable replaces detector with bit.
// (RQ14) Ring override enable replaces detector with bit.
// (RQ15) Byte ready set on byte; read clears.
// (RQ16) Byte ready interrupt enable gates the flag.
// (RQ17) Receiver enable switches byte receiver on.
// (RQ18) Select chooses cooked or raw data.
// (RQ19) Received byte register holds latest character.
// (RQ20) Carrier valid after 25 ms, drops after 8 ms.
// (RQ21) Software reads byte within 8.3 ms.
// (RQ22) Override bits stored but inert when disabled.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`include "cidcs_consts.vh"

module cidcs_top #(
    parameter VALID_CYC = `CIDCS_CAR_VALID_US * `CIDCS_CLK_MHZ,
    parameter DROP_CYC = `CIDCS_CAR_DROP_US * `CIDCS_CLK_MHZ + 1,
    parameter BYTE_BITS = 8
) (
    // Clock and reset.
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address channel.
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data channel.
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response channel.
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address channel.
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data channel.
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Analog front end.
    input wire carrier_raw,
    input wire ring_raw_n,
    input wire demod_cooked,
    input wire demod_raw,
    input wire demod_bit_strobe,
    // Detector power enables toward the analog blocks.
    output wire carrier_power_up,
    output wire ring_power_up,
    // Shared interrupt request.
    output wire irq
);
    // Control registers.
    reg ring_override_bit_reg;
    reg carrier_override_bit_reg;
    reg carrier_irq_enable_reg;
    reg ring_irq_enable_reg;
    reg carrier_irq_flag_reg;
    reg ring_irq_flag_reg;
    reg carrier_power_up_reg;
    reg ring_power_up_reg;
    reg carrier_override_enable_reg;
    reg ring_override_enable_reg;
    reg byte_ready_flag_reg;
    reg byte_ready_irq_enable_reg;
    reg byte_receiver_enable_reg;
    reg raw_data_select_reg;
    reg [7:0] received_byte_reg;
    reg [BYTE_BITS-1:0] shift_reg;
    reg [3:0] bit_cnt_reg;
    reg car_prev_reg;
    reg ring_prev_reg;
    reg [2:0] ring_sync_reg;
    reg ring_level_reg;
    reg [2:0] ser_sync_reg;
    reg ser_level_reg;
    reg [2:0] stb_sync_reg;
    reg stb_level_reg;
    reg stb_prev_reg;

    // Write channel holding state.
    reg aw_have_reg;
    reg w_have_reg;
    reg [7:0] aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;

    wire carrier_valid;
    wire carrier_active;
    wire ring_active;
    wire carrier_present_n;
    wire ring_present_n;
    wire demod_serial_bit;
    wire rx_bit;
    wire stb_rise;
    wire car_rise;
    wire ring_rise;
    wire do_write;
    wire wr_lane0;
    wire do_read;
    wire rd_byte;
    wire [7:0] wd;
    wire [7:0] ctrl1_val;
    wire [7:0] stat2_val;
    wire [7:0] ctrl3_val;

    cidcs_qual #(
        .VALID_CYC(VALID_CYC),
        .DROP_CYC(DROP_CYC)
    ) u_qual (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(carrier_power_up_reg), // RQ11
        .raw_in(carrier_raw),
        .valid(carrier_valid)
    );

    // Ring and demodulator pins are asynchronous; three stages each, and a
    // level is accepted only when stages two and three agree.
    always @(posedge aclk) begin
        if (!aresetn) begin
            ring_sync_reg <= 3'h7;
            ring_level_reg <= 1'b1;
            ser_sync_reg <= 3'h7;
            ser_level_reg <= 1'b1;
            stb_sync_reg <= 3'h0;
            stb_level_reg <= 1'b0;
            stb_prev_reg <= 1'b0;
        end else begin
            ring_sync_reg <= {ring_sync_reg[1:0], ring_raw_n};
            ser_sync_reg <= {ser_sync_reg[1:0],
                             raw_data_select_reg ? demod_raw
                                                 : demod_cooked}; // RQ18
            stb_sync_reg <= {stb_sync_reg[1:0], demod_bit_strobe};
            if (ring_sync_reg[1] == ring_sync_reg[2])
                ring_level_reg <= ring_sync_reg[2];
            if (ser_sync_reg[1] == ser_sync_reg[2])
                ser_level_reg <= ser_sync_reg[2];
            if (stb_sync_reg[1] == stb_sync_reg[2])
                stb_level_reg <= stb_sync_reg[2];
            stb_prev_reg <= stb_level_reg;
        end
    end

    // Overrides take the place of the detector only while enabled; the
    // stored override bit is otherwise ignored.
    assign carrier_active = carrier_override_enable_reg ?
        !carrier_override_bit_reg : carrier_valid; // RQ13 RQ22
    assign ring_active = ring_override_enable_reg ?
        !ring_override_bit_reg : // RQ1 RQ14 RQ22
        (ring_power_up_reg && !ring_level_reg); // RQ12
    assign carrier_present_n = !carrier_active; // RQ8
    assign ring_present_n = !ring_active; // RQ9
    // The serial bit is forced high outside a carrier.
    assign demod_serial_bit = carrier_present_n ? 1'b1 : ser_level_reg; // RQ10
    assign rx_bit = ser_level_reg;
    assign stb_rise = stb_level_reg && !stb_prev_reg;
    assign car_rise = carrier_active && !car_prev_reg;
    assign ring_rise = ring_active && !ring_prev_reg;
    assign carrier_power_up = carrier_power_up_reg;
    assign ring_power_up = ring_power_up_reg;

    // One request line for all three sources.
    assign irq = carrier_irq_flag_reg || ring_irq_flag_reg ||
        (byte_ready_flag_reg && byte_ready_irq_enable_reg); // RQ3 RQ5 RQ16

    // AXI4-Lite: address and data are taken independently and the write
    // commits once both are held and no response is pending.
    assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
    assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
    assign wr_lane0 = do_write && w_strb_reg[0];
    assign wd = w_data_reg[7:0];
    assign s_axi_arready = !s_axi_rvalid;
    assign do_read = s_axi_arvalid && s_axi_arready;
    assign rd_byte = do_read && (s_axi_araddr == `CIDCS_ADDR_RX_BYTE);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // Unmapped or read-only offsets answer with SLVERR.
                s_axi_bresp <= (aw_addr_reg == `CIDCS_ADDR_CTRL1 ||
                                aw_addr_reg == `CIDCS_ADDR_STAT2 ||
                                aw_addr_reg == `CIDCS_ADDR_CTRL3) ?
                               2'b00 : 2'b10;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register views; unused bits read as zero.
    assign ctrl1_val = {ring_irq_flag_reg, ring_irq_enable_reg,
                        carrier_irq_flag_reg, carrier_irq_enable_reg,
                        2'b00, ring_override_bit_reg,
                        carrier_override_bit_reg};
    assign stat2_val = {1'b0, ring_power_up_reg, carrier_power_up_reg,
                        2'b00, demod_serial_bit, ring_present_n,
                        carrier_present_n};
    assign ctrl3_val = {raw_data_select_reg, 2'b00,
                        byte_receiver_enable_reg, byte_ready_irq_enable_reg,
                        byte_ready_flag_reg, ring_override_enable_reg,
                        carrier_override_enable_reg};

    // Read channel with a registered answer one cycle after the address.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else if (do_read) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr)
                `CIDCS_ADDR_CTRL1: s_axi_rdata <= {24'h00_0000, ctrl1_val};
                `CIDCS_ADDR_STAT2: s_axi_rdata <= {24'h00_0000, stat2_val};
                `CIDCS_ADDR_CTRL3: s_axi_rdata <= {24'h00_0000, ctrl3_val};
                `CIDCS_ADDR_RX_BYTE: begin
                    s_axi_rdata <= {24'h00_0000, received_byte_reg}; // RQ19
                end
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Control bits and the carrier and ring flags. A detect edge in the
    // same cycle as a clearing write wins, so no event is lost.
    always @(posedge aclk) begin
        if (!aresetn) begin
            ring_override_bit_reg <= `CIDCS_OVR_RESET; // RQ1
            carrier_override_bit_reg <= `CIDCS_OVR_RESET;
            carrier_irq_enable_reg <= 1'b0;
            ring_irq_enable_reg <= 1'b0;
            carrier_irq_flag_reg <= 1'b0;
            ring_irq_flag_reg <= 1'b0;
            carrier_power_up_reg <= 1'b0;
            ring_power_up_reg <= 1'b0;
            carrier_override_enable_reg <= 1'b0;
            ring_override_enable_reg <= 1'b0;
            byte_ready_irq_enable_reg <= 1'b0;
            byte_receiver_enable_reg <= 1'b0;
            raw_data_select_reg <= 1'b0;
            car_prev_reg <= 1'b0;
            ring_prev_reg <= 1'b0;
        end else begin
            car_prev_reg <= carrier_active;
            ring_prev_reg <= ring_active;
            if (wr_lane0 && aw_addr_reg == `CIDCS_ADDR_CTRL1) begin
                carrier_override_bit_reg <= wd[`CIDCS_B_CAR_OVR]; // RQ22
                ring_override_bit_reg <= wd[`CIDCS_B_RING_OVR];
                carrier_irq_enable_reg <= wd[`CIDCS_B_CAR_IE];
                ring_irq_enable_reg <= wd[`CIDCS_B_RING_IE];
                if (!wd[`CIDCS_B_CAR_IF])
                    carrier_irq_flag_reg <= 1'b0; // RQ4
                if (!wd[`CIDCS_B_RING_IF])
                    ring_irq_flag_reg <= 1'b0; // RQ7
            end
            if (wr_lane0 && aw_addr_reg == `CIDCS_ADDR_STAT2) begin
                carrier_power_up_reg <= wd[`CIDCS_B_CAR_PWR]; // RQ11
                ring_power_up_reg <= wd[`CIDCS_B_RING_PWR]; // RQ12
            end
            if (wr_lane0 && aw_addr_reg == `CIDCS_ADDR_CTRL3) begin
                carrier_override_enable_reg <= wd[`CIDCS_B_CAR_OE];
                ring_override_enable_reg <= wd[`CIDCS_B_RING_OE];
                byte_ready_irq_enable_reg <= wd[`CIDCS_B_RDY_IE];
                byte_receiver_enable_reg <= wd[`CIDCS_B_RX_EN]; // RQ17
                raw_data_select_reg <= wd[`CIDCS_B_RAW_SEL]; // RQ18
            end
            if (car_rise && carrier_irq_enable_reg)
                carrier_irq_flag_reg <= 1'b1; // RQ2 RQ3
            if (ring_rise && ring_irq_enable_reg)
                ring_irq_flag_reg <= 1'b1; // RQ6 RQ7
        end
    end

    // Serial-to-byte receiver: shifts on each bit strobe while a carrier
    // is present. A new byte overwrites an unread one; software has only
    // one character time to collect it.
    always @(posedge aclk) begin
        if (!aresetn || !byte_receiver_enable_reg) begin
            shift_reg <= {BYTE_BITS{1'b0}};
            bit_cnt_reg <= 4'h0;
        end else if (carrier_present_n) begin
            bit_cnt_reg <= 4'h0;
        end else if (stb_rise) begin
            shift_reg <= {rx_bit, shift_reg[BYTE_BITS-1:1]};
            if (bit_cnt_reg == BYTE_BITS[3:0] - 4'd1)
                bit_cnt_reg <= 4'h0;
            else
                bit_cnt_reg <= bit_cnt_reg + 4'd1;
        end
    end

    // Byte capture and ready flag; a completing byte beats a clearing read.
    always @(posedge aclk) begin
        if (!aresetn) begin
            received_byte_reg <= 8'h00;
            byte_ready_flag_reg <= 1'b0;
        end else if (byte_receiver_enable_reg && !carrier_present_n &&
                     stb_rise && bit_cnt_reg == BYTE_BITS[3:0] - 4'd1) begin
            received_byte_reg <= {rx_bit, shift_reg[BYTE_BITS-1:1]}; // RQ19
            byte_ready_flag_reg <= 1'b1; // RQ15
        end else if (rd_byte) begin
            byte_ready_flag_reg <= 1'b0; // RQ15
        end
    end
endmodule
